/* pkg/sfe_pkg.sv */
// Constants, tags and state types of the sensor event stream framer.
// Assumes a 20 MHz system clock; the link side runs on its own clock.
`default_nettype none

package sfe_pkg;

  localparam int CLK_HZ     = 20000000;
  localparam int TS_TICK_HZ = 32000;
  localparam int TICK_DIV   = CLK_HZ / TS_TICK_HZ;

  localparam logic [7:0] TAG_NOP    = 8'h00;
  localparam logic [7:0] TAG_ACCEL  = 8'h01;
  localparam logic [7:0] TAG_STEP   = 8'h13;
  localparam logic [7:0] TAG_TS_LSW = 8'hfc;
  localparam logic [7:0] TAG_TS_MSW = 8'hfd;

  localparam logic [3:0] LEN_TS    = 4'h3;
  localparam logic [3:0] LEN_ACCEL = 4'h8;
  localparam logic [3:0] LEN_STEP  = 4'h3;
  localparam logic [3:0] EV_MAX    = 4'h8;

  localparam int FIFO_DEPTH = 8;
  localparam int RAM_DEPTH  = 256;

  localparam logic [31:0] TS_RST = 32'h0000_0000;

  localparam int N_SENS    = 2;
  localparam int SENS_ACC  = 0;
  localparam int SENS_STEP = 1;

  typedef enum {ST_IDLE, ST_EMIT} sfe_fsm_t;
  typedef enum {EV_MSW, EV_LSW, EV_ACC, EV_STEP} sfe_ev_t;

endpackage

`default_nettype wire

/* pkg/sfe_strm_if.sv */
// Byte stream carrier with valid and ready between framer and FIFO.
// Assumes both ends share the clock of the side they sit on.
`default_nettype none

interface sfe_strm_if #(parameter int W = 8);
  logic         vld;
  logic         rdy;
  logic [W-1:0] dat;
  modport src (output vld, output dat, input rdy);
  modport snk (input vld, input dat, output rdy);
endinterface

`default_nettype wire

/* rtl/sfe_afifo.sv */
// Dual-clock FIFO with gray-coded pointers, valid and ready on both sides.
// Assumes DEPTH is a power of two of at least four.
`default_nettype none

module sfe_afifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic wclk_in,
  input  wire logic rclk_in,
  input  wire logic rst_in,
  sfe_strm_if.snk   wr,
  sfe_strm_if.src   rd
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_r;
  logic [AW:0]  rbin_r;
  logic [AW:0]  wgray_r;
  logic [AW:0]  rgray_r;
  logic [AW:0]  wgray_s;
  logic [AW:0]  rgray_s;
  logic [AW:0]  wbin_nxt;
  logic [AW:0]  rbin_nxt;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  ////////////////////////////////////////////////////////////////////////////////
  assign full     = wgray_r == {~rgray_s[AW:AW-1], rgray_s[AW-2:0]};
  assign empty    = rgray_r == wgray_s;
  assign wr.rdy   = !full;
  assign rd.vld   = !empty;
  assign rd.dat   = mem[rbin_r[AW-1:0]];
  assign push     = wr.vld && !full;
  assign pop      = rd.rdy && !empty;
  assign wbin_nxt = push ? wbin_r + 1'b1 : wbin_r;
  assign rbin_nxt = pop ? rbin_r + 1'b1 : rbin_r;

  always_ff @(posedge wclk_in)
  begin
    if (push)
      mem[wbin_r[AW-1:0]] <= wr.dat;
  end

  always_ff @(posedge wclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wbin_r  <= '0;
      wgray_r <= '0;
    end
    else
    begin
      wbin_r  <= wbin_nxt;
      wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
    end
  end

  always_ff @(posedge rclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rbin_r  <= '0;
      rgray_r <= '0;
    end
    else
    begin
      rbin_r  <= rbin_nxt;
      rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
    end
  end

  sfe_sync #(.W(AW + 1)) u_rptr_sync (
    .clk_in (wclk_in),
    .rst_in (rst_in),
    .d_in   (rgray_r),
    .q_out  (rgray_s)
  );

  sfe_sync #(.W(AW + 1)) u_wptr_sync (
    .clk_in (rclk_in),
    .rst_in (rst_in),
    .d_in   (wgray_r),
    .q_out  (wgray_s)
  );

endmodule

`default_nettype wire

/* rtl/sfe_sync.sv */
// Two flip-flop synchroniser for levels and gray-coded words.
// Assumes the input changes at most one bit at a time.
`default_nettype none

module sfe_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic [W-1:0]      q_out
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_r <= '0;
      q_out  <= '0;
    end
    else
    begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule

`default_nettype wire

/* rtl/sfe_top.sv */
// Sensor event framer: batches samples as tagged byte events in a ring,
// then hands each flushed batch to the link side through a dual-clock FIFO.
// Assumes sensor inputs and latencies are on clk_in; link reads on link_clk_in.
`default_nettype none

// Operation
// - Timestamp low event: tag 252 then low 16 timestamp bits, low byte first.
// - On high-word change emit tag 253 high event, then low event, before sample.
// - Accel event: tag 1, X, Y, Z low byte first, then status byte.
// - Step event: tag 19 then 16-bit step count, low byte first.
// - Timestamp advances at 32000 ticks per second.
// - Samples are held until the sensor latency expires, then host is interrupted.
// - A zero-latency sensor output flushes the batch and interrupts at once.
// - Every batch starts and ends on whole event boundaries.
// - Reads past the reported count return zero, the one-byte no-op tag.
module sfe_top #(
  parameter int RAM_DEPTH  = sfe_pkg::RAM_DEPTH,
  parameter int FIFO_DEPTH = sfe_pkg::FIFO_DEPTH
) (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        link_clk_in,
  input  wire logic        acc_vld_in,
  output logic             acc_rdy_out,
  input  wire logic [15:0] acc_x_in,
  input  wire logic [15:0] acc_y_in,
  input  wire logic [15:0] acc_z_in,
  input  wire logic [7:0]  acc_stat_in,
  input  wire logic [15:0] acc_lat_in,
  input  wire logic        step_vld_in,
  output logic             step_rdy_out,
  input  wire logic [15:0] step_cnt_in,
  input  wire logic [15:0] step_lat_in,
  output logic             host_irq_out,
  output logic [15:0]      xfer_cnt_out,
  input  wire logic        rd_stb_in,
  output logic             rd_rdy_out,
  output logic [7:0]       rd_data_out
);

  localparam int          AW        = $clog2(RAM_DEPTH);
  localparam int          TICK_W    = $clog2(sfe_pkg::TICK_DIV);
  localparam logic [AW:0] RAM_SIZE  = (AW + 1)'(RAM_DEPTH);
  localparam logic [AW:0] ROOM_MIN  = (AW + 1)'(sfe_pkg::EV_MAX);
  localparam logic [TICK_W-1:0] TICK_LAST = (TICK_W)'(sfe_pkg::TICK_DIV - 1);

  logic [TICK_W-1:0] tick_cnt_r;
  logic              tick;
  logic [31:0]       ts_r;
  logic              acc_pend_r;
  logic [15:0]       acc_x_r;
  logic [15:0]       acc_y_r;
  logic [15:0]       acc_z_r;
  logic [7:0]        acc_stat_r;
  logic              step_pend_r;
  logic [15:0]       step_cnt_r;
  sfe_pkg::sfe_fsm_t state_r;
  sfe_pkg::sfe_ev_t  load_kind;
  sfe_pkg::sfe_ev_t  ev_kind_r;
  logic [7:0]        ev_buf_r [sfe_pkg::EV_MAX];
  logic [3:0]        ev_len_r;
  logic [3:0]        ev_idx_r;
  logic [15:0]       last_hi_r;
  logic [15:0]       last_lo_r;
  logic              new_batch_r;
  logic [7:0]        ram [RAM_DEPTH];
  logic [AW:0]       wr_ptr_r;
  logic [AW:0]       rd_ptr_r;
  logic [AW:0]       commit_r;
  logic [15:0]       batch_len_r;
  logic              ram_we;
  logic              room;
  logic              load;
  logic              publish;
  logic              flush_go;
  logic              flush_req_r;
  logic              samp_done;
  logic              samp_sens;
  logic              zero_done;
  logic [15:0]       sens_lat [sfe_pkg::N_SENS];
  logic [15:0]       tmr_r [sfe_pkg::N_SENS];
  logic [sfe_pkg::N_SENS-1:0] arm_r;
  logic [sfe_pkg::N_SENS-1:0] expire;
  logic              req_tgl_r;
  logic [15:0]       pub_cnt_r;
  logic              ack_s;
  logic              hs_busy;
  logic              req_s;
  logic              req_seen_r;
  logic              ack_tgl_r;
  logic [15:0]       remain_r;
  logic              pop;
  logic              new_req;

  sfe_strm_if #(.W(8)) wr_if ();
  sfe_strm_if #(.W(8)) rd_if ();

  ////////////////////////////////////////////////////////////////////////////////
  // Timestamp base
  assign tick = tick_cnt_r == TICK_LAST;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      tick_cnt_r <= '0;
    else
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      ts_r <= sfe_pkg::TS_RST;
    else if (tick)
      ts_r <= ts_r + 32'h0000_0001;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sample holding, one slot per sensor
  assign acc_rdy_out  = !acc_pend_r;
  assign step_rdy_out = !step_pend_r;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      acc_pend_r <= 1'b0;
      acc_x_r    <= 16'h0000;
      acc_y_r    <= 16'h0000;
      acc_z_r    <= 16'h0000;
      acc_stat_r <= 8'h00;
    end
    else if (acc_vld_in && !acc_pend_r)
    begin
      acc_pend_r <= 1'b1;
      acc_x_r    <= acc_x_in;
      acc_y_r    <= acc_y_in;
      acc_z_r    <= acc_z_in;
      acc_stat_r <= acc_stat_in;
    end
    else if (load && load_kind == sfe_pkg::EV_ACC)
      acc_pend_r <= 1'b0;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      step_pend_r <= 1'b0;
      step_cnt_r  <= 16'h0000;
    end
    else if (step_vld_in && !step_pend_r)
    begin
      step_pend_r <= 1'b1;
      step_cnt_r  <= step_cnt_in;
    end
    else if (load && load_kind == sfe_pkg::EV_STEP)
      step_pend_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event selection; an event is only started with room for the longest one,
  // so emission never stalls halfway and batches close on event boundaries
  assign room     = (RAM_SIZE - (wr_ptr_r - rd_ptr_r)) >= ROOM_MIN;
  assign flush_go = flush_req_r && !hs_busy && batch_len_r != 16'h0000;
  assign publish  = state_r == sfe_pkg::ST_IDLE && flush_go;
  assign load     = state_r == sfe_pkg::ST_IDLE && !flush_go && room &&
                    (acc_pend_r || step_pend_r);

  always_comb
  begin
    if (ts_r[31:16] != last_hi_r)
      load_kind = sfe_pkg::EV_MSW;
    else if (ts_r[15:0] != last_lo_r || new_batch_r)
      load_kind = sfe_pkg::EV_LSW;
    else if (acc_pend_r)
      load_kind = sfe_pkg::EV_ACC;
    else
      load_kind = sfe_pkg::EV_STEP;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      last_hi_r   <= 16'h0000;
      last_lo_r   <= 16'h0000;
      new_batch_r <= 1'b1;
    end
    else if (publish)
      new_batch_r <= 1'b1;
    else if (load && load_kind == sfe_pkg::EV_MSW)
    begin
      // Low word always follows, even if its value happens to repeat
      last_hi_r   <= ts_r[31:16];
      new_batch_r <= 1'b1;
    end
    else if (load && load_kind == sfe_pkg::EV_LSW)
    begin
      last_lo_r   <= ts_r[15:0];
      new_batch_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ev_kind_r <= sfe_pkg::EV_LSW;
      ev_len_r  <= 4'h0;
      for (int i = 0; i < sfe_pkg::EV_MAX; i++)
        ev_buf_r[i] <= 8'h00;
    end
    else if (load)
    begin
      ev_kind_r <= load_kind;
      case (load_kind)
        sfe_pkg::EV_MSW:
        begin
          ev_buf_r[0] <= sfe_pkg::TAG_TS_MSW;
          ev_buf_r[1] <= ts_r[23:16];
          ev_buf_r[2] <= ts_r[31:24];
          ev_len_r    <= sfe_pkg::LEN_TS;
        end
        sfe_pkg::EV_LSW:
        begin
          ev_buf_r[0] <= sfe_pkg::TAG_TS_LSW;
          ev_buf_r[1] <= ts_r[7:0];
          ev_buf_r[2] <= ts_r[15:8];
          ev_len_r    <= sfe_pkg::LEN_TS;
        end
        sfe_pkg::EV_ACC:
        begin
          ev_buf_r[0] <= sfe_pkg::TAG_ACCEL;
          ev_buf_r[1] <= acc_x_r[7:0];
          ev_buf_r[2] <= acc_x_r[15:8];
          ev_buf_r[3] <= acc_y_r[7:0];
          ev_buf_r[4] <= acc_y_r[15:8];
          ev_buf_r[5] <= acc_z_r[7:0];
          ev_buf_r[6] <= acc_z_r[15:8];
          ev_buf_r[7] <= acc_stat_r;
          ev_len_r    <= sfe_pkg::LEN_ACCEL;
        end
        default:
        begin
          ev_buf_r[0] <= sfe_pkg::TAG_STEP;
          ev_buf_r[1] <= step_cnt_r[7:0];
          ev_buf_r[2] <= step_cnt_r[15:8];
          ev_len_r    <= sfe_pkg::LEN_STEP;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Byte emission into the batch ring
  assign ram_we    = state_r == sfe_pkg::ST_EMIT;
  assign samp_done = ram_we && ev_idx_r == ev_len_r - 4'h1 &&
                     (ev_kind_r == sfe_pkg::EV_ACC || ev_kind_r == sfe_pkg::EV_STEP);
  assign samp_sens = ev_kind_r == sfe_pkg::EV_STEP;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_r  <= sfe_pkg::ST_IDLE;
      ev_idx_r <= 4'h0;
    end
    else
    begin
      case (state_r)
        sfe_pkg::ST_IDLE:
        begin
          ev_idx_r <= 4'h0;
          if (load)
            state_r <= sfe_pkg::ST_EMIT;
        end
        default:
        begin
          ev_idx_r <= (ev_idx_r == ev_len_r - 4'h1) ? 4'h0 : ev_idx_r + 4'h1;
          if (ev_idx_r == ev_len_r - 4'h1)
            state_r <= sfe_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (ram_we)
      ram[wr_ptr_r[AW-1:0]] <= ev_buf_r[ev_idx_r[2:0]];
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wr_ptr_r    <= '0;
      batch_len_r <= 16'h0000;
      commit_r    <= '0;
    end
    else if (publish)
    begin
      batch_len_r <= 16'h0000;
      commit_r    <= wr_ptr_r;
    end
    else if (ram_we)
    begin
      wr_ptr_r    <= wr_ptr_r + 1'b1;
      batch_len_r <= batch_len_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Latency timers in timestamp ticks, armed by a sensor's first sample
  assign sens_lat[sfe_pkg::SENS_ACC]  = acc_lat_in;
  assign sens_lat[sfe_pkg::SENS_STEP] = step_lat_in;
  assign zero_done = samp_done && sens_lat[samp_sens] == 16'h0000;

  always_comb
  begin
    for (int s = 0; s < sfe_pkg::N_SENS; s++)
      expire[s] = arm_r[s] && tick && tmr_r[s] == 16'h0001;
  end

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      arm_r <= '0;
      for (int s = 0; s < sfe_pkg::N_SENS; s++)
        tmr_r[s] <= 16'h0000;
    end
    else
    begin
      for (int s = 0; s < sfe_pkg::N_SENS; s++)
      begin
        if (publish || expire[s])
          arm_r[s] <= 1'b0;
        else if (samp_done && samp_sens == s[0] && !arm_r[s] && sens_lat[s] != 16'h0000)
        begin
          arm_r[s] <= 1'b1;
          tmr_r[s] <= sens_lat[s];
        end
        else if (arm_r[s] && tick)
          tmr_r[s] <= tmr_r[s] - 16'h0001;
      end
    end
  end

  // New causes win over the clear of a publish in the same cycle
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      flush_req_r <= 1'b0;
    else if (zero_done || (|expire))
      flush_req_r <= 1'b1;
    else if (publish)
      flush_req_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Hand-off: count held stable while the toggle is unanswered
  assign hs_busy = req_tgl_r != ack_s;

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      req_tgl_r    <= 1'b0;
      pub_cnt_r    <= 16'h0000;
      host_irq_out <= 1'b0;
    end
    else
    begin
      if (publish)
      begin
        req_tgl_r <= ~req_tgl_r;
        pub_cnt_r <= batch_len_r;
      end
      host_irq_out <= publish || hs_busy;
    end
  end

  sfe_sync #(.W(1)) u_ack_sync (
    .clk_in (clk_in),
    .rst_in (sys_rst_in),
    .d_in   (ack_tgl_r),
    .q_out  (ack_s)
  );

  // Only committed bytes drain, so the FIFO never holds a partial batch
  assign wr_if.vld = rd_ptr_r != commit_r;
  assign wr_if.dat = ram[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      rd_ptr_r <= '0;
    else if (wr_if.vld && wr_if.rdy)
      rd_ptr_r <= rd_ptr_r + 1'b1;
  end

  sfe_afifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wclk_in (clk_in),
    .rclk_in (link_clk_in),
    .rst_in  (sys_rst_in),
    .wr      (wr_if.snk),
    .rd      (rd_if.src)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Link side
  sfe_sync #(.W(1)) u_req_sync (
    .clk_in (link_clk_in),
    .rst_in (sys_rst_in),
    .d_in   (req_tgl_r),
    .q_out  (req_s)
  );

  assign new_req    = req_s != req_seen_r;
  assign pop        = rd_stb_in && remain_r != 16'h0000 && rd_if.vld;
  assign rd_if.rdy  = pop;
  assign rd_rdy_out = remain_r == 16'h0000 || rd_if.vld;

  always_ff @(posedge link_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      req_seen_r   <= 1'b0;
      xfer_cnt_out <= 16'h0000;
      remain_r     <= 16'h0000;
      ack_tgl_r    <= 1'b0;
    end
    else if (new_req)
    begin
      req_seen_r   <= req_s;
      xfer_cnt_out <= pub_cnt_r;
      remain_r     <= pub_cnt_r;
    end
    else if (pop)
    begin
      remain_r <= remain_r - 16'h0001;
      if (remain_r == 16'h0001)
        ack_tgl_r <= ~ack_tgl_r;
    end
  end

  always_ff @(posedge link_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      rd_data_out <= 8'h00;
    else if (pop)
      rd_data_out <= rd_if.dat;
    else if (rd_stb_in && remain_r == 16'h0000)
      rd_data_out <= sfe_pkg::TAG_NOP;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_emit3;
    ram_we [*3] ##1 !ram_we;
  endsequence

  sequence s_emit8;
    ram_we [*8] ##1 !ram_we;
  endsequence

  property p_ts_tick;
    @(posedge clk_in) disable iff (sys_rst_in)
      tick |=> (ts_r == $past(ts_r) + 32'h0000_0001) ##1 (!tick) [*8];
  endproperty
  a_ts_tick: assert property (p_ts_tick) else $error("timestamp tick wrong");

  property p_lsw;
    @(posedge clk_in) disable iff (sys_rst_in)
      (load && load_kind == sfe_pkg::EV_LSW) |=>
        (ev_buf_r[0] == sfe_pkg::TAG_TS_LSW && {ev_buf_r[2], ev_buf_r[1]} == $past(ts_r[15:0]))
        ##0 s_emit3;
  endproperty
  a_lsw: assert property (p_lsw) else $error("low word event malformed");

  property p_msw;
    @(posedge clk_in) disable iff (sys_rst_in)
      (load && load_kind == sfe_pkg::EV_MSW) |=>
        (ev_buf_r[0] == sfe_pkg::TAG_TS_MSW && {ev_buf_r[2], ev_buf_r[1]} == $past(ts_r[31:16]))
        ##0 s_emit3;
  endproperty
  a_msw: assert property (p_msw) else $error("high word event malformed");

  property p_samp_ts;
    @(posedge clk_in) disable iff (sys_rst_in)
      (load && (load_kind == sfe_pkg::EV_ACC || load_kind == sfe_pkg::EV_STEP)) |->
        (ts_r[31:16] == last_hi_r && ts_r[15:0] == last_lo_r && !new_batch_r);
  endproperty
  a_samp_ts: assert property (p_samp_ts) else $error("sample without current timestamp");

  property p_acc;
    @(posedge clk_in) disable iff (sys_rst_in)
      (load && load_kind == sfe_pkg::EV_ACC) |=>
        (ev_buf_r[0] == sfe_pkg::TAG_ACCEL && {ev_buf_r[2], ev_buf_r[1]} == $past(acc_x_r)
         && {ev_buf_r[4], ev_buf_r[3]} == $past(acc_y_r)
         && {ev_buf_r[6], ev_buf_r[5]} == $past(acc_z_r) && ev_buf_r[7] == $past(acc_stat_r))
        ##0 s_emit8;
  endproperty
  a_acc: assert property (p_acc) else $error("accel event malformed");

  property p_step;
    @(posedge clk_in) disable iff (sys_rst_in)
      (load && load_kind == sfe_pkg::EV_STEP) |=>
        (ev_buf_r[0] == sfe_pkg::TAG_STEP && {ev_buf_r[2], ev_buf_r[1]} == $past(step_cnt_r))
        ##0 s_emit3;
  endproperty
  a_step: assert property (p_step) else $error("step event malformed");

  property p_zero_flush;
    @(posedge clk_in) disable iff (sys_rst_in)
      (zero_done && !hs_busy) |-> ##1 publish ##1 host_irq_out;
  endproperty
  a_zero_flush: assert property (p_zero_flush) else $error("zero latency not flushed");

  property p_lat_flush;
    @(posedge clk_in) disable iff (sys_rst_in)
      ((|expire) && !hs_busy) |-> ##[1:10] publish;
  endproperty
  a_lat_flush: assert property (p_lat_flush) else $error("latency expiry not flushed");

  property p_boundary;
    @(posedge clk_in) disable iff (sys_rst_in)
      publish |-> (ev_idx_r == 4'h0) ##1 (commit_r == wr_ptr_r && batch_len_r == 16'h0000);
  endproperty
  a_boundary: assert property (p_boundary) else $error("batch not on event boundary");

  property p_pad;
    @(posedge link_clk_in) disable iff (sys_rst_in)
      (rd_stb_in && remain_r == 16'h0000 && !new_req) |=> rd_data_out == sfe_pkg::TAG_NOP;
  endproperty
  a_pad: assert property (p_pad) else $error("read past count not zero");

endmodule

`default_nettype wire

/* verif/sfe_host.sv */
// Host model: on each interrupt reads the count, then count plus two bytes.
// Assumes the count settles within six link edges of the interrupt.
`default_nettype none

module sfe_host (
  input  wire logic        lclk_in,
  input  wire logic        irq_in,
  input  wire logic [15:0] cnt_in,
  input  wire logic        rdy_in,
  input  wire logic [7:0]  data_in,
  output logic             stb_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  got [$];
  logic [15:0] n;
  int          batches = 0;

  initial
  begin
    stb_out = 1'b0;
    forever
    begin
      @(posedge lclk_in);
      if (irq_in === 1'b1)
      begin
        got.delete();
        repeat (6) @(posedge lclk_in);
        n = cnt_in;
        // Two reads past the count probe the padding
        for (int i = 0; i < n + 2; i++)
        begin
          #1 stb_out = 1'b1;
          @(posedge lclk_in);
          while (rdy_in !== 1'b1) @(posedge lclk_in);
          #1 stb_out = 1'b0;
          @(posedge lclk_in);
          #1 got.push_back(data_in);
        end
        while (irq_in === 1'b1) @(posedge lclk_in);
        batches++;
      end
    end
  end
endmodule

`default_nettype wire

/* verif/tb.sv */
// Bench for the event framer: offers samples, host model drains batches.
// Assumes the host model above on the link clock.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 0, lclk = 0, rst = 1, a_vld = 0, s_vld = 0, stb, a_rdy, s_rdy;
  logic        irq, rrdy;
  logic [15:0] ax = 0, ay = 0, az = 0, lat_a = 16'h0002, lat_s = 16'h0100, sc = 0, cnt;
  logic [7:0]  st = 8'h02, rdat;
  int          err_count = 0, check_count = 0, cyc = 0, d, n, t0;

  sfe_top dut (.clk_in(clk_in), .sys_rst_in(rst), .link_clk_in(lclk), .acc_vld_in(a_vld),
    .acc_rdy_out(a_rdy), .acc_x_in(ax), .acc_y_in(ay), .acc_z_in(az), .acc_stat_in(st),
    .acc_lat_in(lat_a), .step_vld_in(s_vld), .step_rdy_out(s_rdy), .step_cnt_in(sc),
    .step_lat_in(lat_s), .host_irq_out(irq), .xfer_cnt_out(cnt), .rd_stb_in(stb),
    .rd_rdy_out(rrdy), .rd_data_out(rdat));
  sfe_host host (.lclk_in(lclk), .irq_in(irq), .cnt_in(cnt), .rdy_in(rrdy),
    .data_in(rdat), .stb_out(stb));

  initial forever #25 clk_in = ~clk_in;
  initial
  begin
    #3;
    forever #7.5 lclk = ~lclk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      conclude();
    end
  end

  // Raise valid only while ready is up, so the next edge takes it
  task automatic offer(input logic s);
    while ((s ? s_rdy : a_rdy) !== 1'b1) @(posedge clk_in) #2;
    if (s) s_vld = 1'b1; else a_vld = 1'b1;
    @(posedge clk_in) #2;
    a_vld = 1'b0;
    s_vld = 1'b0;
  endtask

  task automatic wait_irq;
    d = cyc;
    for (int k = 0; k < 2000 && irq !== 1'b1; k++) @(posedge clk_in);
    d = cyc - d;
  endtask

  task automatic wait_batch(input int b);
    for (int k = 0; k < 4000 && host.batches < b; k++) @(posedge clk_in);
    chk(host.batches, b);
    n = host.n;
  endtask

  task automatic t_accel;
    logic [7:0] e [11] = '{8'hfc, 0, 0, 8'h01, 8'hfe, 8'hff, 8'h05, 8'h00, 8'h69, 8'h08, 8'h02};
    ax = 16'hfffe;
    ay = 16'h0005;
    az = 16'h0869;
    offer(0);
    wait_irq();
    chk(d > 625 && d < 1320, 1);
    wait_batch(1);
    chk(n, 11);
    chk(host.got[0], 8'hfc);
    chk({host.got[2], host.got[1]}, 16'h0000);
    for (int i = 3; i < 11; i++) chk(host.got[i], e[i]);
    chk({host.got[11], host.got[12]}, 16'h0000);
    $display("accel batch test done");
  endtask

  task automatic t_step;
    logic [7:0] e [8] = '{8'h01, 8'hff, 8'hff, 8'h11, 8'h00, 8'h82, 8'h07, 8'h02};
    int         co;
    lat_a = 16'h0100;
    lat_s = 16'h0000;
    ax = 16'hffff;
    ay = 16'h0011;
    az = 16'h0782;
    sc = 16'h0001;
    co = cyc;
    offer(0);
    offer(1);
    wait_irq();
    chk(d < 100, 1);
    wait_batch(2);
    chk(n == 14 || n == 17, 1);
    chk({host.got[3], host.got[0]}, 16'h01fc);
    for (int i = 0; i < 8; i++) chk(host.got[i+3], e[i]);
    // Timestamp counts whole ticks since reset; load may fall one tick later
    chk({host.got[2], host.got[1]} - (co - t0) / 625 <= 1, 1);
    chk(host.got[n-3], 8'h13);
    chk({host.got[n-1], host.got[n-2]}, 16'h0001);
    chk(host.got[n], 8'h00);
    $display("zero latency step test done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk_in);
    #2 rst = 1'b0;
    t0 = cyc;
    t_accel();
    t_step();
    conclude();
  end
endmodule

`default_nettype wire
